/* rtl/mmad_pkg.sv */
// memory map constants, region codes and range helper for the address decoder
package mmad_pkg;
  // ----------------------------------------
  // address space
  // ----------------------------------------
  localparam int ADDR_W = 13;
  localparam logic [12:0] IO_FIRST = 13'h0000;
  localparam logic [12:0] IO_LAST = 13'h001f;
  localparam logic [12:0] PZ_FIRST = 13'h0020;
  localparam logic [12:0] PZ_LAST = 13'h004f;
  localparam logic [12:0] RAM_FIRST = 13'h0050;
  localparam logic [12:0] RAM_LAST = 13'h00ff;
  localparam logic [12:0] STACK_LOW = 13'h00c0;
  localparam logic [12:0] STACK_TOP = 13'h00ff;
  localparam logic [12:0] MAIN_FIRST = 13'h0100;
  localparam logic [12:0] MAIN_LAST = 13'h12ff;
  localparam logic [12:0] BOOT_FIRST = 13'h1f01;
  localparam logic [12:0] BOOT_LAST = 13'h1fef;
  localparam logic [12:0] VEC_FIRST = 13'h1ff0;
  localparam logic [12:0] VEC_LAST = 13'h1fff;
  // ----------------------------------------
  // peripheral register locations
  // ----------------------------------------
  localparam logic [12:0] PORT_DATA_BASE = 13'h0000;
  localparam logic [12:0] PORT_DIR_BASE = 13'h0004;
  localparam int PORT_NUM = 4;
  localparam logic [12:0] ADC_RESULT_ADDR = 13'h001d;
  localparam logic [12:0] ADC_CTRL_ADDR = 13'h001e;
  localparam logic [12:0] WDOG_ADDR = 13'h1ff0;
  localparam int WDOG_BIT = 0;
  // one bit per control page byte: set where a register exists
  localparam logic [31:0] IO_IMPL_MASK = 32'h7fec1cff;
  // ----------------------------------------
  // regions, one-hot
  // ----------------------------------------
  typedef enum logic [6:0] {
    MMAD_NONE = 7'h01,
    MMAD_IO = 7'h02,
    MMAD_PZ = 7'h04,
    MMAD_RAM = 7'h08,
    MMAD_MAIN = 7'h10,
    MMAD_BOOT = 7'h20,
    MMAD_VEC = 7'h40
  } mmad_region_t;

  // inclusive range test
  function automatic logic in_range(input logic [12:0] a, input logic [12:0] lo, input logic [12:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction
endpackage

/* rtl/mmad_region.sv */
// combinational region classifier for one 13-bit address
`timescale 1ns/1ns
module mmad_region
  import mmad_pkg::*;
(
  // address in
  input wire logic [12:0] i_addr,
  // classification out
  output mmad_region_t o_region,
  output logic o_io_impl
);
  // ----------------------------------------
  // region select, no mode input: same map in every mode
  // ----------------------------------------
  always_comb begin
    if (in_range(i_addr, IO_FIRST, IO_LAST)) begin
      o_region = MMAD_IO;
    end else if (in_range(i_addr, PZ_FIRST, PZ_LAST)) begin
      o_region = MMAD_PZ;
    end else if (in_range(i_addr, RAM_FIRST, RAM_LAST)) begin
      o_region = MMAD_RAM;
    end else if (in_range(i_addr, MAIN_FIRST, MAIN_LAST)) begin
      o_region = MMAD_MAIN;
    end else if (in_range(i_addr, BOOT_FIRST, BOOT_LAST)) begin
      o_region = MMAD_BOOT;
    end else if (in_range(i_addr, VEC_FIRST, VEC_LAST)) begin
      o_region = MMAD_VEC;
    end else begin
      o_region = MMAD_NONE;
    end
  end

  // ----------------------------------------
  // control page byte that holds a register
  // ----------------------------------------
  assign o_io_impl = (o_region == MMAD_IO) && IO_IMPL_MASK[i_addr[4:0]];
endmodule

/* rtl/mmad_top.sv */
// address decoder for the 8 KB internal memory space
//
// Function
// - Decode a 13-bit address covering 8 KB in I/O, RAM, ROM, EPROM.
// - User mode enables 32-byte I/O page, RAM, user EPROM and boot ROM together.
// - Bootloader mode uses exactly the same map as user mode.
// - Unimplemented control page bits read undefined, writes have no effect.
// - 176-byte RAM with stack sits at 0x0050..0x00FF.
// - Stack grows down from 0x00FF, reaching only 0x00C0..0x00FF.
// - Main user EPROM, 4608 bytes, at 0x0100..0x12FF.
// - Page-zero user EPROM, 48 bytes, at 0x0020..0x004F.
// - User vector EPROM, 16 bytes, at 0x1FF0..0x1FFF.
// - Bootloader ROM with vectors at 0x1F01..0x1FEF.
// - Write with bit 0 low to 0x1FF0 restarts watchdog; reads give EPROM.
// - Port A..D data registers at 0x0000..0x0003.
// - Port A..D direction registers at 0x0004..0x0007.
// - Converter result at 0x001D, converter control/status at 0x001E.
`timescale 1ns/1ns
module mmad_top
  import mmad_pkg::*;
#(
  parameter int PORTS = PORT_NUM
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // processor bus cycle
  input wire logic [12:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  // memory region selects
  output mmad_region_t o_region,
  output logic o_stack,
  output logic o_rd_en,
  output logic o_wr_en,
  output logic o_rd_undef,
  // peripheral register selects
  output logic [PORTS-1:0] o_port_data_sel,
  output logic [PORTS-1:0] o_port_dir_sel,
  output logic o_adc_result_sel,
  output logic o_adc_ctrl_sel,
  output logic o_io_other_sel,
  // watchdog
  output logic o_watchdog_timer_restart
);
  // ----------------------------------------
  // classification
  // ----------------------------------------
  mmad_region_t region;
  logic io_impl;
  logic access;
  logic mapped;
  logic [12:0] port_off;

  mmad_region u_region (
    .i_addr(i_addr),
    .o_region(region),
    .o_io_impl(io_impl)
  );

  // a byte is mapped when it is memory or an existing control register
  assign access = i_rd | i_wr;
  assign mapped = (region != MMAD_NONE) && ((region != MMAD_IO) || io_impl);
  assign port_off = i_addr - PORT_DATA_BASE;

  // ----------------------------------------
  // region and stack outputs
  // ----------------------------------------
  // region is held per access, none between cycles
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_region <= MMAD_NONE;
      o_stack <= 1'b0;
    end else begin
      o_region <= access ? region : MMAD_NONE;
      o_stack <= access && in_range(i_addr, STACK_LOW, STACK_TOP);
    end
  end

  // ----------------------------------------
  // read/write enables
  // ----------------------------------------
  // holes and unmapped bytes: no enable, read data flagged undefined
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_en <= 1'b0;
      o_wr_en <= 1'b0;
      o_rd_undef <= 1'b0;
    end else begin
      o_rd_en <= i_rd && mapped;
      o_wr_en <= i_wr && mapped;
      o_rd_undef <= i_rd && !mapped;
    end
  end

  // ----------------------------------------
  // peripheral selects
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_port_data_sel <= '0;
      o_port_dir_sel <= '0;
      o_adc_result_sel <= 1'b0;
      o_adc_ctrl_sel <= 1'b0;
      o_io_other_sel <= 1'b0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        o_port_data_sel[p] <= access && (port_off == 13'(p));
        o_port_dir_sel[p] <= access && (port_off == 13'(p) + (PORT_DIR_BASE - PORT_DATA_BASE));
      end
      o_adc_result_sel <= access && (i_addr == ADC_RESULT_ADDR);
      o_adc_ctrl_sel <= access && (i_addr == ADC_CTRL_ADDR);
      o_io_other_sel <= access && io_impl && !in_range(i_addr, PORT_DATA_BASE, PORT_DIR_BASE + 13'(PORTS - 1))
        && (i_addr != ADC_RESULT_ADDR) && (i_addr != ADC_CTRL_ADDR);
    end
  end

  // ----------------------------------------
  // watchdog restart
  // ----------------------------------------
  // write-only side effect; the read still goes to vector EPROM
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_watchdog_timer_restart <= 1'b0;
    end else begin
      o_watchdog_timer_restart <= i_wr && (i_addr == WDOG_ADDR) && !i_wdata[WDOG_BIT];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  ram_range_a: assert property (access && in_range(i_addr, RAM_FIRST, RAM_LAST) |=> o_region == MMAD_RAM)
    else $error("ram address not decoded as ram");
  stack_range_a: assert property (o_stack |-> o_region == MMAD_RAM && $past(i_addr) >= 13'h00c0)
    else $error("stack flag outside top 64 bytes");
  main_eprom_a: assert property (access && i_addr == 13'h12ff |=> o_region == MMAD_MAIN)
    else $error("last main eprom byte missed");
  page_zero_a: assert property (access && i_addr >= 13'h0020 && i_addr <= 13'h004f |=> o_region == MMAD_PZ)
    else $error("page zero eprom missed");
  vector_area_a: assert property (access && i_addr >= 13'h1ff0 |=> o_region == MMAD_VEC && o_rd_en == $past(i_rd))
    else $error("vector area missed");
  boot_rom_a: assert property (o_region == MMAD_BOOT |-> $past(i_addr) >= 13'h1f01 && $past(i_addr) <= 13'h1fef)
    else $error("boot rom outside its range");
  wdog_restart_a: assert property (i_wr && i_addr == 13'h1ff0 && !i_wdata[0] |=> o_watchdog_timer_restart
    ##1 !o_watchdog_timer_restart || $past(i_wr))
    else $error("watchdog restart not pulsed");
  wdog_read_a: assert property (i_rd && !i_wr && i_addr == 13'h1ff0 |=> !o_watchdog_timer_restart && o_rd_en)
    else $error("watchdog read did not read eprom");
  port_data_a: assert property (access && i_addr == 13'h0002 |=> o_port_data_sel == 4'h4 && o_port_dir_sel == 4'h0)
    else $error("port c data select wrong");
  port_dir_a: assert property (access && i_addr == 13'h0007 |=> o_port_dir_sel == 4'h8 && o_port_data_sel == 4'h0)
    else $error("port d direction select wrong");
  adc_sel_a: assert property (access && i_addr == 13'h001e |=> o_adc_ctrl_sel && !o_adc_result_sel)
    else $error("converter control select wrong");
  io_hole_a: assert property (i_wr && i_addr == 13'h0008 |=> !o_wr_en && o_region == MMAD_IO)
    else $error("write to control page hole accepted");
  gap_none_a: assert property (access && i_addr >= 13'h1300 && i_addr <= 13'h1f00 |=>
    o_region == MMAD_NONE && !o_wr_en && o_rd_undef == $past(i_rd))
    else $error("unmapped gap selected something");
  one_region_a: assert property ($onehot(o_region))
    else $error("region code not one-hot");

  // ----------------------------------------
  // checks: region edges
  // ----------------------------------------
  // edge bytes of the control page, main EPROM, boot ROM and stack band, where an off-by-one compare would hide
  io_page_a: assert property (access && i_addr <= 13'h001f |=> o_region == MMAD_IO)
    else $error("control page address not decoded as io");
  main_first_a: assert property (access && i_addr == 13'h0100 |=> o_region == MMAD_MAIN)
    else $error("first main eprom byte missed");
  boot_first_a: assert property (access && i_addr == 13'h1f01 |=> o_region == MMAD_BOOT)
    else $error("first boot rom byte missed");
  boot_last_a: assert property (access && i_addr == 13'h1fef |=> o_region == MMAD_BOOT)
    else $error("last boot rom byte missed");
  stack_hit_a: assert property (access && i_addr >= 13'h00c0 && i_addr <= 13'h00ff |=> o_stack)
    else $error("stack byte not flagged");
  stack_low_a: assert property (access && i_addr == 13'h00bf |=> !o_stack && o_region == MMAD_RAM)
    else $error("byte below stack flagged as stack");

  // ----------------------------------------
  // checks: control page
  // ----------------------------------------
  // shared select must not overlap the dedicated port and converter selects
  io_other_a: assert property (access && i_addr == 13'h000a |=> o_io_other_sel && !o_adc_ctrl_sel
    && !o_adc_result_sel && o_port_data_sel == 4'h0 && o_port_dir_sel == 4'h0)
    else $error("other control register select wrong");
  adc_result_a: assert property (access && i_addr == 13'h001d |=> o_adc_result_sel && !o_adc_ctrl_sel)
    else $error("converter result select wrong");
  hole_read_a: assert property (i_rd && i_addr == 13'h001f |=> o_rd_undef && !o_rd_en
    && o_region == MMAD_IO)
    else $error("read of reserved byte not flagged undefined");
  both_access_a: assert property (i_rd && i_wr && i_addr == 13'h0005 |=> o_rd_en && o_wr_en
    && o_port_dir_sel == 4'h2)
    else $error("combined read and write cycle mis-decoded");

  // ----------------------------------------
  // checks: watchdog
  // ----------------------------------------
  // only a write of bit 0 low to the one address may restart the timer
  wdog_data_a: assert property (i_wr && i_addr == 13'h1ff0 && i_wdata[0] |=> !o_watchdog_timer_restart)
    else $error("watchdog restarted with bit 0 high");
  wdog_addr_a: assert property (!(i_wr && i_addr == 13'h1ff0) |=> !o_watchdog_timer_restart)
    else $error("watchdog restarted by another cycle");

  // ----------------------------------------
  // checks: idle and unmapped
  // ----------------------------------------
  // an idle cycle must leave every select low in the next cycle
  idle_quiet_a: assert property (!i_rd && !i_wr |=> o_region == MMAD_NONE && !o_stack && !o_rd_en
    && !o_wr_en && !o_rd_undef && o_port_data_sel == 4'h0 && o_port_dir_sel == 4'h0 && !o_adc_result_sel
    && !o_adc_ctrl_sel && !o_io_other_sel && !o_watchdog_timer_restart)
    else $error("outputs active in an idle cycle");
  gap_read_a: assert property (i_rd && i_addr == 13'h1f00 |=> o_rd_undef && !o_rd_en
    && o_region == MMAD_NONE)
    else $error("byte below boot rom not unmapped");

  stack_cov: cover property (access ##1 o_stack);
  wdog_cov: cover property (o_watchdog_timer_restart);
  boot_cov: cover property (o_region == MMAD_BOOT ##1 o_region == MMAD_VEC);
  undef_cov: cover property (o_rd_undef);
  hole_cov: cover property (o_rd_undef && o_region == MMAD_IO);
endmodule

/* verif/memory_map_address_decoder_tb_top.sv */
// self-checking bench for the memory map address decoder
`timescale 1ns/1ns
module memory_map_address_decoder_tb_top;
  import mmad_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [12:0] addr;
  logic rd;
  logic wr;
  logic [7:0] wdata;
  mmad_region_t region;
  logic stack;
  logic rd_en;
  logic wr_en;
  logic rd_undef;
  logic [3:0] pdata;
  logic [3:0] pdir;
  logic adc_res;
  logic adc_ctrl;
  logic io_other;
  logic wdog;
  int n_mismatch = 0;
  int n_tests = 0;

  // 125 MHz clock
  always #4 i_clk = ~i_clk;

  mmad_cpu_model cpu (.i_clk(i_clk), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));

  mmad_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wdata),
    .o_region(region), .o_stack(stack), .o_rd_en(rd_en), .o_wr_en(wr_en), .o_rd_undef(rd_undef),
    .o_port_data_sel(pdata), .o_port_dir_sel(pdir), .o_adc_result_sel(adc_res), .o_adc_ctrl_sel(adc_ctrl),
    .o_io_other_sel(io_other), .o_watchdog_timer_restart(wdog));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one access, outputs sampled at the following falling edge
  task automatic acc(input logic r, input logic w, input logic [12:0] a, input logic [7:0] d);
    cpu.drive(r, w, a, d);
    @(negedge i_clk);
  endtask

  function automatic mmad_region_t exp_reg(input logic [12:0] a);
    if (a <= 13'h001f) return MMAD_IO;
    if (a <= 13'h004f) return MMAD_PZ;
    if (a <= 13'h00ff) return MMAD_RAM;
    if (a <= 13'h12ff) return MMAD_MAIN;
    if (a >= 13'h1ff0) return MMAD_VEC;
    if (a >= 13'h1f01) return MMAD_BOOT;
    return MMAD_NONE;
  endfunction

  task automatic test_map();
    logic [12:0] tbl [16] = '{13'h0000, 13'h001f, 13'h0020, 13'h004f, 13'h0050, 13'h00bf, 13'h00c0, 13'h00ff,
      13'h0100, 13'h12ff, 13'h1300, 13'h1f00, 13'h1f01, 13'h1fef, 13'h1ff0, 13'h1fff};
    mmad_region_t r;
    logic ok;
    foreach (tbl[i]) begin
      r = exp_reg(tbl[i]);
      ok = (r == MMAD_IO) ? IO_IMPL_MASK[tbl[i][4:0]] : (r != MMAD_NONE);
      acc(1'b1, 1'b0, tbl[i], 8'h00);
      chk("region", region, r);
      chk("rd_en", rd_en, ok);
      chk("rd_undef", rd_undef, !ok);
      chk("stack", stack, tbl[i] >= 13'h00c0 && tbl[i] <= 13'h00ff);
    end
    $display("test map done");
  endtask

  task automatic test_regs();
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, 1'b0, 13'(i), 8'h00);
      chk("pdata", pdata, i < 4 ? 4'h1 << i : 4'h0);
      chk("pdir", pdir, i >= 4 ? 4'h1 << (i - 4) : 4'h0);
    end
    acc(1'b1, 1'b0, 13'h001d, 8'h00);
    chk("adc_res", {adc_res, adc_ctrl}, 2'h2);
    acc(1'b0, 1'b1, 13'h001e, 8'h3c);
    chk("adc_ctrl", {adc_res, adc_ctrl, wr_en}, 3'h3);
    acc(1'b0, 1'b1, 13'h000a, 8'h11);
    chk("io_other", {io_other, wr_en}, 2'h3);
    acc(1'b0, 1'b1, 13'h0008, 8'h11);
    chk("hole_wr", {region, io_other, wr_en}, {MMAD_IO, 2'h0});
    acc(1'b0, 1'b1, 13'h1500, 8'h00);
    chk("gap_wr", {region, wr_en, wdog}, {MMAD_NONE, 2'h0});
    acc(1'b1, 1'b1, 13'h0005, 8'h01);
    chk("rd_wr", {rd_en, wr_en, pdir}, 6'h32);
    $display("test regs done");
  endtask

  task automatic test_wdog();
    acc(1'b0, 1'b1, 13'h1ff0, 8'hfe);
    chk("wdog_wr0", {region, wr_en, wdog}, {MMAD_VEC, 2'h3});
    acc(1'b0, 1'b1, 13'h1ff0, 8'h01);
    chk("wdog_wr1", wdog, 1'b0);
    acc(1'b1, 1'b0, 13'h1ff0, 8'h00);
    chk("wdog_rd", {region, rd_en, wdog}, {MMAD_VEC, 2'h2});
    acc(1'b0, 1'b1, 13'h1ff1, 8'h00);
    chk("wdog_addr", wdog, 1'b0);
    acc(1'b0, 1'b0, 13'h1ff0, 8'h00);
    chk("idle", {region, rd_en, wr_en, wdog}, {MMAD_NONE, 3'h0});
    $display("test wdog done");
  endtask

  // reset dropped while a restart write is held, then released under it
  task automatic test_reset();
    acc(1'b0, 1'b1, 13'h1ff0, 8'h00);
    chk("pre_rst", wdog, 1'b1);
    i_rst_n = 1'b0;
    #1;
    chk("in_rst", {region, wr_en, wdog, rd_undef}, {MMAD_NONE, 3'h0});
    @(negedge i_clk);
    i_rst_n = 1'b1;
    @(negedge i_clk);
    chk("post_rst", {region, wr_en, wdog}, {MMAD_VEC, 2'h3});
    acc(1'b0, 1'b0, 13'h0000, 8'h00);
    $display("test reset done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // reset, then the scenarios
  initial begin
    repeat (2) @(negedge i_clk);
    chk("rst_region", region, MMAD_NONE);
    i_rst_n = 1'b1;
    test_map();
    test_regs();
    test_wdog();
    test_reset();
    summarize();
  end

  // hang guard, about 25 times the expected run
  initial begin
    repeat (2000) @(posedge i_clk);
    n_mismatch++;
    summarize();
  end
endmodule

/* verif/mmad_cpu_model.sv */
// processor core model issuing read and write bus cycles
`timescale 1ns/1ns
module mmad_cpu_model (
  // clock
  input wire logic i_clk,
  // bus cycle out
  output logic [12:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_wdata
);
  // bus idle at time zero
  initial begin
    o_addr = 13'h0000;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'h5a;
  end

  // one cycle launched after a falling edge, held until the next call
  task automatic drive(input logic rd, input logic wr, input logic [12:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_rd = rd;
    o_wr = wr;
    o_addr = a;
    o_wdata = wr ? d : ~o_wdata; // data lines not driven by reads: keep them moving
  endtask
endmodule
